// File: rtccr_top.sv
// rtc control register, cascaded count bytes, calendar time, axi4-lite slave
//
// The implementer's own choices: the register addresses and the AXI4-Lite slave port.
`default_nettype none
module rtccr_top
  import rtccr_pkg::*;
#(
  parameter int ADDR_W = 5
) (
  input  wire logic              clock_in,
  input  wire logic              rstn_in,
  input  wire logic              aux_clock_in,
  input  wire logic              subsystem_clock_in,
  input  wire logic              prescaler_tap_in,
  input  wire logic              irq_service_in,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output logic                   prescaler_irq_flag_out,
  output logic                   prescaler_hold_out,
  output logic                   irq_out
);
  if (ADDR_W < 5) begin : g_chk
    $error("ADDR_W must cover the register map");
  end

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic [1:0] rst_sync_q;
  logic       rstn;
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rstn = rst_sync_q[1];

  // ----------------------------------------------------------------
  // source clock sampling: three flops, change counts when 2nd and 3rd agree
  // ----------------------------------------------------------------
  logic [2:0] src_pin;
  logic [2:0] src_s1_q;
  logic [2:0] src_s2_q;
  logic [2:0] src_s3_q;
  logic [2:0] src_lvl_q;
  logic [2:0] src_edge;
  assign src_pin = {prescaler_tap_in, subsystem_clock_in, aux_clock_in};
  for (genvar i = 0; i < 3; i++) begin : g_src
    always_ff @(posedge clock_in or negedge rstn) begin
      if (!rstn) begin
        src_s1_q[i]  <= 1'b0;
        src_s2_q[i]  <= 1'b0;
        src_s3_q[i]  <= 1'b0;
        src_lvl_q[i] <= 1'b0;
      end else begin
        src_s1_q[i] <= src_pin[i];
        src_s2_q[i] <= src_s1_q[i];
        src_s3_q[i] <= src_s2_q[i];
        if (src_s2_q[i] == src_s3_q[i]) begin
          src_lvl_q[i] <= src_s3_q[i];
        end
      end
    end
    assign src_edge[i] = (src_s2_q[i] == src_s3_q[i]) && src_s3_q[i] && !src_lvl_q[i];
  end

  // ----------------------------------------------------------------
  // control fields and source selection
  // ----------------------------------------------------------------
  logic [7:0]      ctrl_q;
  logic [3:0][7:0] cnt_q;
  logic [3:0][7:0] cnt_d;
  rtccr_mode_t     mode;
  rtccr_evt_t      evsel;
  logic            cal;
  logic            bcd;
  logic            hold;
  logic            ie;
  logic            tick;
  logic            src_sel;
  assign mode  = rtccr_mode_t'(ctrl_q[RTCCR_MODE_HI:RTCCR_MODE_LO]);
  assign evsel = rtccr_evt_t'(ctrl_q[RTCCR_EVT_HI:RTCCR_EVT_LO]);
  assign cal   = (mode == RTCCR_MODE_CAL);
  assign bcd   = ctrl_q[RTCCR_BIT_BCD] && cal;
  assign hold  = ctrl_q[RTCCR_BIT_HOLD];
  assign ie    = ctrl_q[RTCCR_BIT_IE];
  always_comb begin
    unique case (mode)
      RTCCR_MODE_AUX: src_sel = src_edge[0];
      RTCCR_MODE_SUB: src_sel = src_edge[1];
      RTCCR_MODE_TAP: src_sel = src_edge[2];
      RTCCR_MODE_CAL: src_sel = src_edge[2];
    endcase
  end
  assign tick               = src_sel && !hold;
  assign prescaler_hold_out = hold && cal;

  // ----------------------------------------------------------------
  // axi4-lite write address, data and response channels
  // ----------------------------------------------------------------
  logic              aw_have_q;
  logic              w_have_q;
  logic [ADDR_W-1:0] aw_addr_q;
  logic [7:0]        w_data_q;
  logic              w_lane_q;
  logic              wr_go;
  logic              wr_ok;
  logic              wr_ctrl;
  logic [3:0]        wr_cnt;
  logic              wr_status;
  logic              wr_mask;
  assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_have_q && !s_axi_bvalid;
  assign wr_go         = aw_have_q && w_have_q && !s_axi_bvalid;
  always_comb begin
    wr_ctrl   = 1'b0;
    wr_cnt    = 4'h0;
    wr_status = 1'b0;
    wr_mask   = 1'b0;
    wr_ok     = 1'b1;
    unique case (aw_addr_q[4:0])
      RTCCR_OFF_CTRL:   wr_ctrl   = 1'b1;
      RTCCR_OFF_CNT1:   wr_cnt[0] = 1'b1;
      RTCCR_OFF_CNT2:   wr_cnt[1] = 1'b1;
      RTCCR_OFF_CNT3:   wr_cnt[2] = 1'b1;
      RTCCR_OFF_CNT4:   wr_cnt[3] = 1'b1;
      RTCCR_OFF_STATUS: wr_status = 1'b1;
      RTCCR_OFF_MASK:   wr_mask   = 1'b1;
      default:          wr_ok     = 1'b0;
    endcase
    if (aw_addr_q[ADDR_W-1:0] >> 5 != '0) begin
      wr_ok = 1'b0;
    end
    if (!(wr_go && w_lane_q && wr_ok)) begin
      wr_ctrl   = 1'b0;
      wr_cnt    = 4'h0;
      wr_status = 1'b0;
      wr_mask   = 1'b0;
    end
  end
  always_ff @(posedge clock_in or negedge rstn) begin
    if (!rstn) begin
      aw_have_q    <= 1'b0;
      w_have_q     <= 1'b0;
      aw_addr_q    <= '0;
      w_data_q     <= 8'h00;
      w_lane_q     <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RTCCR_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        w_data_q <= s_axi_wdata[7:0];
        w_lane_q <= s_axi_wstrb[0];
      end
      if (wr_go) begin
        aw_have_q    <= 1'b0;
        w_have_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? RTCCR_RESP_OKAY : RTCCR_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // counting: a byte write wins over the tick for that byte only; the
  // other bytes still advance, so only the written byte's tick may be lost
  // ----------------------------------------------------------------
  function automatic logic [8:0] cal_next(input logic [7:0] v, input logic [7:0] vmax, input logic in_bcd);
    logic [8:0] r;
    r = {1'b0, v + 8'h01};
    if (v == vmax) begin
      r = 9'h100;
    end else if (in_bcd && v[3:0] == 4'h9) begin
      r = {1'b0, v[7:4] + 4'h1, 4'h0};
    end
    return r;
  endfunction

  logic [8:0]  sec_n;
  logic [8:0]  min_n;
  logic [8:0]  hour_n;
  logic [8:0]  dow_n;
  logic [32:0] cnt_sum;
  logic [3:0]  ovf;
  logic [3:0]  cal_ev;
  logic        event_hit;
  logic        wrap_hit;
  logic        fmt_clear;
  logic [7:0]  tmask;
  logic [7:0]  wmask [4];
  assign tmask    = bcd ? RTCCR_MASK_BCD : RTCCR_MASK_HEX;
  assign wmask[0] = cal ? tmask : 8'hFF;
  assign wmask[1] = cal ? tmask : 8'hFF;
  assign wmask[2] = cal ? RTCCR_MASK_HEX : 8'hFF;
  assign wmask[3] = cal ? RTCCR_MASK_DOW : 8'hFF;
  assign sec_n    = cal_next(cnt_q[0], bcd ? RTCCR_SEC_MAX_BCD : RTCCR_SEC_MAX_HEX, bcd);
  assign min_n    = cal_next(cnt_q[1], bcd ? RTCCR_SEC_MAX_BCD : RTCCR_SEC_MAX_HEX, bcd);
  assign hour_n   = cal_next(cnt_q[2], bcd ? RTCCR_HOUR_MAX_BCD : RTCCR_HOUR_MAX_HEX, bcd);
  assign dow_n    = cal_next(cnt_q[3], RTCCR_DOW_MAX, 1'b0);
  assign cnt_sum  = {1'b0, cnt_q} + 33'h1;
  // overflow of byte i means all bytes up to i were at FF when the tick came
  for (genvar i = 0; i < 4; i++) begin : g_ovf
    assign ovf[i] = tick && !cal && (cnt_q[i:0] == '1);
  end
  assign cal_ev[0] = tick && cal && sec_n[8];
  assign cal_ev[1] = cal_ev[0] && min_n[8];
  assign cal_ev[2] = cal_ev[1] && hour_n[8];
  assign cal_ev[3] = cal_ev[1] && (hour_n[7:0] == (bcd ? RTCCR_NOON_BCD : RTCCR_NOON_HEX));
  assign event_hit = cal ? cal_ev[evsel] : ovf[evsel];
  assign wrap_hit  = cal ? cal_ev[2] : ovf[3];
  // crossing the calendar boundary either way or flipping the format clears the time
  assign fmt_clear = wr_ctrl && ((w_data_q[RTCCR_BIT_BCD] != ctrl_q[RTCCR_BIT_BCD])
                     || ((w_data_q[RTCCR_MODE_HI:RTCCR_MODE_LO] == 2'h3) != cal));

  always_comb begin
    cnt_d = cnt_q;
    if (tick && !cal) begin
      cnt_d = cnt_sum[31:0];
    end else if (tick) begin
      cnt_d[0] = sec_n[7:0];
      if (sec_n[8]) begin
        cnt_d[1] = min_n[7:0];
      end
      if (sec_n[8] && min_n[8]) begin
        cnt_d[2] = hour_n[7:0];
      end
      if (cal_ev[2]) begin
        cnt_d[3] = dow_n[7:0];
      end
    end
    for (int i = 0; i < 4; i++) begin
      if (wr_cnt[i]) begin
        cnt_d[i] = w_data_q & wmask[i];
      end
    end
    if (fmt_clear) begin
      cnt_d = '0;
    end
  end
  always_ff @(posedge clock_in or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= {4{RTCCR_CNT_RESET}};
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // ----------------------------------------------------------------
  // control register and flags: a hardware set beats every clear
  // ----------------------------------------------------------------
  logic [1:0] status_q;
  logic [1:0] mask_q;
  logic [1:0] status_set;
  always_ff @(posedge clock_in or negedge rstn) begin
    if (!rstn) begin
      ctrl_q <= RTCCR_CTRL_RESET;
    end else begin
      if (wr_ctrl) begin
        ctrl_q[7:1] <= w_data_q[7:1];
      end
      if (event_hit) begin
        ctrl_q[RTCCR_BIT_FLAG] <= 1'b1;
      end else if (wr_ctrl) begin
        ctrl_q[RTCCR_BIT_FLAG] <= w_data_q[RTCCR_BIT_FLAG];
      end else if (irq_service_in && ie) begin
        ctrl_q[RTCCR_BIT_FLAG] <= 1'b0;
      end
    end
  end
  always_ff @(posedge clock_in or negedge rstn) begin
    if (!rstn) begin
      prescaler_irq_flag_out <= 1'b0;
    end else if (event_hit && ie) begin
      prescaler_irq_flag_out <= 1'b1;
    end else if (irq_service_in) begin
      prescaler_irq_flag_out <= 1'b0;
    end
  end
  assign status_set = {wrap_hit, event_hit};
  always_ff @(posedge clock_in or negedge rstn) begin
    if (!rstn) begin
      status_q <= RTCCR_ST_RESET;
      mask_q   <= RTCCR_ST_RESET;
    end else begin
      status_q <= (status_q & ~(wr_status ? w_data_q[1:0] : 2'h0)) | status_set;
      if (wr_mask) begin
        mask_q <= w_data_q[1:0];
      end
    end
  end
  assign irq_out = |(status_q & mask_q);

  // ----------------------------------------------------------------
  // read channel: data registered at the address handshake
  // ----------------------------------------------------------------
  logic [7:0] rd_byte;
  logic       rd_ok;
  always_comb begin
    rd_ok = (s_axi_araddr >> 5) == '0;
    unique case (s_axi_araddr[4:0])
      RTCCR_OFF_CTRL:   rd_byte = ctrl_q;
      RTCCR_OFF_CNT1:   rd_byte = cnt_q[0];
      RTCCR_OFF_CNT2:   rd_byte = cnt_q[1];
      RTCCR_OFF_CNT3:   rd_byte = cnt_q[2];
      RTCCR_OFF_CNT4:   rd_byte = cnt_q[3];
      RTCCR_OFF_STATUS: rd_byte = {6'h00, status_q};
      RTCCR_OFF_MASK:   rd_byte = {6'h00, mask_q};
      default: begin
        rd_byte = 8'h00;
        rd_ok   = 1'b0;
      end
    endcase
  end
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge clock_in or negedge rstn) begin
    if (!rstn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RTCCR_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= {24'h00_0000, rd_ok ? rd_byte : 8'h00};
      s_axi_rresp  <= rd_ok ? RTCCR_RESP_OKAY : RTCCR_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_hold_freezes: assert property (
    @(posedge clock_in) disable iff (!rstn) (hold && wr_cnt == 4'h0 && !fmt_clear) |=> $stable(cnt_q))
    else $error("count moved while held");
  a_sub_counts: assert property (
    @(posedge clock_in) disable iff (!rstn)
    (mode == RTCCR_MODE_SUB && src_edge[1] && !hold && wr_cnt == 4'h0 && !fmt_clear)
    |=> cnt_q[0] == 8'($past(cnt_q[0]) + 8'h01))
    else $error("subsystem tick did not increment");
  a_aux_only: assert property (
    @(posedge clock_in) disable iff (!rstn)
    (mode == RTCCR_MODE_AUX && !src_edge[0] && wr_cnt == 4'h0 && !fmt_clear) |=> $stable(cnt_q))
    else $error("count moved without aux tick");
  a_byte_write: assert property (
    @(posedge clock_in) disable iff (!rstn) (wr_cnt[2] && !cal && !fmt_clear) |=> cnt_q[2] == $past(w_data_q))
    else $error("count byte write lost");
  a_flag_sets: assert property (
    @(posedge clock_in) disable iff (!rstn) event_hit |=> ctrl_q[RTCCR_BIT_FLAG] && status_q[RTCCR_ST_EVENT])
    else $error("time event flag not set");
  a_ie_gates: assert property (
    @(posedge clock_in) disable iff (!rstn) (event_hit && !ie) |=> !$rose(prescaler_irq_flag_out))
    else $error("shared flag set with interrupt disabled");
  a_service_clears: assert property (
    @(posedge clock_in) disable iff (!rstn)
    (irq_service_in && ie && !event_hit && !wr_ctrl) |=> !ctrl_q[RTCCR_BIT_FLAG] && !prescaler_irq_flag_out)
    else $error("service did not clear flags");
  a_minute_bits: assert property (
    @(posedge clock_in) disable iff (!rstn) cal |-> !cnt_q[1][7] && (bcd || !cnt_q[1][6]))
    else $error("fixed-zero minute bits set");
  a_format_clear: assert property (
    @(posedge clock_in) disable iff (!rstn) fmt_clear |=> cnt_q == '0)
    else $error("format change did not clear time");
endmodule : rtccr_top
`default_nettype wire

// File: rtccr_pkg.sv
// package: register map, field layout and constants of the rtc control and count block
`default_nettype none
package rtccr_pkg;
  // ----------------------------------------------------------------
  // register byte addresses on the axi4-lite bus
  // ----------------------------------------------------------------
  localparam logic [4:0] RTCCR_OFF_CTRL   = 5'h00;
  localparam logic [4:0] RTCCR_OFF_CNT1   = 5'h04;
  localparam logic [4:0] RTCCR_OFF_CNT2   = 5'h08;
  localparam logic [4:0] RTCCR_OFF_CNT3   = 5'h0C;
  localparam logic [4:0] RTCCR_OFF_CNT4   = 5'h10;
  localparam logic [4:0] RTCCR_OFF_STATUS = 5'h14;
  localparam logic [4:0] RTCCR_OFF_MASK   = 5'h18;
  // ----------------------------------------------------------------
  // clock_control fields
  // ----------------------------------------------------------------
  localparam int RTCCR_BIT_BCD  = 7;
  localparam int RTCCR_BIT_HOLD = 6;
  localparam int RTCCR_MODE_HI  = 5;
  localparam int RTCCR_MODE_LO  = 4;
  localparam int RTCCR_EVT_HI   = 3;
  localparam int RTCCR_EVT_LO   = 2;
  localparam int RTCCR_BIT_IE   = 1;
  localparam int RTCCR_BIT_FLAG = 0;
  localparam logic [7:0] RTCCR_CTRL_RESET = 8'h40;
  localparam logic [7:0] RTCCR_CNT_RESET  = 8'h00;
  // ----------------------------------------------------------------
  // interrupt status bits
  // ----------------------------------------------------------------
  localparam int RTCCR_ST_EVENT = 0;
  localparam int RTCCR_ST_WRAP  = 1;
  localparam logic [1:0] RTCCR_ST_RESET = 2'h0;
  // ----------------------------------------------------------------
  // calendar limits and write masks
  // ----------------------------------------------------------------
  localparam logic [7:0] RTCCR_SEC_MAX_HEX  = 8'h3B;
  localparam logic [7:0] RTCCR_SEC_MAX_BCD  = 8'h59;
  localparam logic [7:0] RTCCR_HOUR_MAX_HEX = 8'h17;
  localparam logic [7:0] RTCCR_HOUR_MAX_BCD = 8'h23;
  localparam logic [7:0] RTCCR_NOON_HEX     = 8'h0C;
  localparam logic [7:0] RTCCR_NOON_BCD     = 8'h12;
  localparam logic [7:0] RTCCR_DOW_MAX      = 8'h06;
  localparam logic [7:0] RTCCR_MASK_HEX     = 8'h3F;
  localparam logic [7:0] RTCCR_MASK_BCD     = 8'h7F;
  localparam logic [7:0] RTCCR_MASK_DOW     = 8'h07;
  localparam logic [1:0] RTCCR_RESP_OKAY    = 2'h0;
  localparam logic [1:0] RTCCR_RESP_SLVERR  = 2'h2;
  typedef enum logic [1:0] {
    RTCCR_MODE_AUX,
    RTCCR_MODE_TAP,
    RTCCR_MODE_SUB,
    RTCCR_MODE_CAL
  } rtccr_mode_t;
  typedef enum logic [1:0] {
    RTCCR_EV_FIRST,
    RTCCR_EV_SECOND,
    RTCCR_EV_THIRD,
    RTCCR_EV_FOURTH
  } rtccr_evt_t;
endpackage : rtccr_pkg
`default_nettype wire

// File: test_rtccr_top.sv
// self-checking testbench for the rtc control and count register block
`default_nettype none
module test_rtccr_top
  import rtccr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rstn, aux, sub, tap, svc;
  logic [4:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic        awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic        pflag, phold, irq;
  int          num_errors, n_compared;

  rtccr_top uut (
    .clock_in(clk), .rstn_in(rstn), .aux_clock_in(aux), .subsystem_clock_in(sub),
    .prescaler_tap_in(tap), .irq_service_in(svc),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .prescaler_irq_flag_out(pflag), .prescaler_hold_out(phold), .irq_out(irq)
  );

  always #25 clk = ~clk;

  // ----------------------------------------------------------------
  // bus and pin helpers
  // ----------------------------------------------------------------
  task automatic test_done();
    if (num_errors == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : test_done

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // ready is sampled mid-cycle, where it is settled, and acted on at the next edge
  task automatic wr(input logic [4:0] a, input logic [7:0] d, output logic [1:0] r);
    bit ad, dd, got;
    ad = 0; dd = 0; got = 0;
    awaddr <= a; wdata <= {24'h0, d}; awvalid <= 1'b1; wvalid <= 1'b1;
    while (!(ad && dd)) begin
      @(negedge clk);
      ad = ad | (awvalid & awready);
      dd = dd | (wvalid & wready);
      @(posedge clk);
      if (ad) awvalid <= 1'b0;
      if (dd) wvalid <= 1'b0;
    end
    while (!got) begin
      @(negedge clk);
      got = bvalid; r = bresp;
      @(posedge clk);
    end
  endtask : wr

  task automatic rd(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
    bit tk, got;
    tk = 0; got = 0;
    araddr <= a; arvalid <= 1'b1;
    while (!tk) begin
      @(negedge clk);
      tk = arready;
      @(posedge clk);
    end
    arvalid <= 1'b0;
    while (!got) begin
      @(negedge clk);
      got = rvalid; d = rdata; r = rresp;
      @(posedge clk);
    end
  endtask : rd

  task automatic w(input logic [4:0] a, input logic [7:0] d);
    logic [1:0] r;
    wr(a, d, r);
  endtask : w

  task automatic rc(input logic [4:0] a, input logic [7:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    chk($sformatf("data at %h", a), d, {24'h0, e});
    chk($sformatf("resp at %h", a), {30'h0, r}, {30'h0, RTCCR_RESP_OKAY});
  endtask : rc

  task automatic pk(input string n, ref logic s, input logic e);
    @(negedge clk);
    chk(n, {31'h0, s}, {31'h0, e});
    @(posedge clk);
  endtask : pk

  function automatic logic [4:0] ca(input int i);
    return 5'(RTCCR_OFF_CNT1 + 4 * i);
  endfunction : ca

  // one rising edge on a source pin: 0 aux, 1 tap, 2 subsystem; long enough for the synchroniser
  task automatic tick(input int p);
    case (p)
      0: aux <= 1'b1;
      1: tap <= 1'b1;
      default: sub <= 1'b1;
    endcase
    repeat (6) @(posedge clk);
    aux <= 1'b0; tap <= 1'b0; sub <= 1'b0;
    repeat (8) @(posedge clk);
  endtask : tick

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    logic [31:0] d;
    logic [1:0]  r;
    rc(RTCCR_OFF_CTRL, RTCCR_CTRL_RESET);
    for (int i = 0; i < 4; i++) rc(ca(i), RTCCR_CNT_RESET);
    rc(RTCCR_OFF_STATUS, 8'h00);
    rc(RTCCR_OFF_MASK, 8'h00);
    pk("irq", irq, 1'b0);
    pk("prescaler hold", phold, 1'b0);
    rd(5'h1C, d, r);
    chk("unmapped data", d, 32'h0);
    chk("unmapped resp", {30'h0, r}, {30'h0, RTCCR_RESP_SLVERR});
    wr(5'h1C, 8'hFF, r);
    chk("unmapped wresp", {30'h0, r}, {30'h0, RTCCR_RESP_SLVERR});
  endtask : t_reset

  task automatic t_bytes();
    logic [1:0] r;
    w(RTCCR_OFF_CTRL, 8'h40);
    for (int p = 0; p < 2; p++) begin
      for (int i = 0; i < 4; i++) w(ca(i), (p ? 8'h5A : 8'hA5) ^ 8'(i));
      for (int i = 0; i < 4; i++) rc(ca(i), (p ? 8'h5A : 8'hA5) ^ 8'(i));
    end
    wstrb <= 4'h0;
    wr(ca(0), 8'h00, r);
    wstrb <= 4'hF;
    chk("no-lane wresp", {30'h0, r}, {30'h0, RTCCR_RESP_OKAY});
    rc(ca(0), 8'h5A);
  endtask : t_bytes

  // each counter mode must count only its own source pin, and nothing while held
  task automatic t_count();
    for (int m = 0; m < 3; m++) begin
      w(RTCCR_OFF_CTRL, {2'b01, 2'(m), 4'h0});
      w(ca(0), 8'h00);
      w(RTCCR_OFF_CTRL, {2'b00, 2'(m), 4'h0});
      for (int p = 0; p < 3; p++) tick(p);
      rc(ca(0), 8'h01);
      w(RTCCR_OFF_CTRL, {2'b01, 2'(m), 4'h0});
      tick(m);
      rc(ca(0), 8'h01);
    end
  endtask : t_count

  task automatic t_ovf();
    logic ie;
    for (int ev = 0; ev < 4; ev++) begin
      ie = (ev != 1);
      w(RTCCR_OFF_CTRL, 8'h50);
      for (int j = 0; j < 4; j++) w(ca(j), (j <= ev) ? 8'hFF : 8'h00);
      w(RTCCR_OFF_CTRL, {2'b00, 2'b01, 2'(ev), ie, 1'b0});
      tick(1);
      rc(RTCCR_OFF_CTRL, {2'b00, 2'b01, 2'(ev), ie, 1'b1});
      pk("prescaler flag", pflag, ie);
      rc((ev < 3) ? ca(ev + 1) : ca(0), (ev < 3) ? 8'h01 : 8'h00);
      rc(RTCCR_OFF_STATUS, (ev == 3) ? 8'h03 : 8'h01);
      pk("irq masked", irq, 1'b0);
      w(RTCCR_OFF_MASK, 8'h01);
      pk("irq unmasked", irq, 1'b1);
      svc <= 1'b1;
      @(posedge clk);
      svc <= 1'b0;
      repeat (2) @(posedge clk);
      rc(RTCCR_OFF_CTRL, {2'b00, 2'b01, 2'(ev), ie, !ie});
      pk("prescaler flag serviced", pflag, 1'b0);
      w(RTCCR_OFF_STATUS, 8'h03);
      rc(RTCCR_OFF_STATUS, 8'h00);
      pk("irq cleared", irq, 1'b0);
      w(RTCCR_OFF_MASK, 8'h00);
      // a plain increment with no carry must not raise the flag again
      w(RTCCR_OFF_CTRL, {2'b00, 2'b01, 2'(ev), ie, 1'b0});
      tick(1);
      rc(RTCCR_OFF_CTRL, {2'b00, 2'b01, 2'(ev), ie, 1'b0});
    end
  endtask : t_ovf

  task automatic t_cal();
    w(RTCCR_OFF_CTRL, 8'h50);
    w(ca(1), 8'h12);
    w(RTCCR_OFF_CTRL, 8'hF0);
    rc(ca(1), 8'h00);
    pk("prescaler hold", phold, 1'b1);
    w(ca(1), 8'hFF);
    rc(ca(1), 8'h7F);
    w(ca(1), 8'h09);
    w(ca(0), 8'h59);
    w(RTCCR_OFF_CTRL, 8'hB2);
    pk("prescaler run", phold, 1'b0);
    tick(1);
    rc(ca(0), 8'h00);
    rc(ca(1), 8'h10);
    rc(RTCCR_OFF_CTRL, 8'hB3);
    w(RTCCR_OFF_CTRL, 8'h70);
    rc(ca(1), 8'h00);
    w(ca(1), 8'hFF);
    rc(ca(1), 8'h3F);
    w(ca(1), 8'h09);
    w(ca(0), 8'h3B);
    w(RTCCR_OFF_CTRL, 8'h32);
    tick(1);
    rc(ca(1), 8'h0A);
    rc(RTCCR_OFF_CTRL, 8'h33);
    w(RTCCR_OFF_CTRL, 8'hFC);
    w(ca(2), 8'h11);
    w(ca(1), 8'h59);
    w(ca(0), 8'h59);
    w(RTCCR_OFF_CTRL, 8'hBE);
    tick(1);
    rc(ca(2), 8'h12);
    rc(RTCCR_OFF_CTRL, 8'hBF);
  endtask : t_cal

  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    clk = 0; rstn = 0; aux = 0; sub = 0; tap = 0; svc = 0;
    awaddr = '0; araddr = '0; wdata = '0; wstrb = 4'hF;
    awvalid = 0; wvalid = 0; arvalid = 0; bready = 1; rready = 1;
    num_errors = 0; n_compared = 0;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    t_reset();
    t_bytes();
    t_count();
    t_ovf();
    t_cal();
    test_done();
  end

  // the tests need fewer than a thousand cycles; this bound leaves ample margin
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    test_done();
  end
endmodule : test_rtccr_top
`default_nettype wire
